// [core/faer_pkg.sv]
// Package for the fatal alarm error register block
`default_nettype none
package faer_pkg;
    // Instruction decode
    localparam logic [7:0]  FUNC_SEVERE_ALARM = 8'h07;
    localparam logic [15:0] ALARM_NUM_MIN     = 16'h0001;
    localparam logic [15:0] ALARM_NUM_MAX     = 16'h01ff;
    localparam logic [15:0] USER_CODE_BASE    = 16'hc100;
    // System error codes and their detail masks or exact patterns
    localparam logic [15:0] SYS_MEMORY        = 16'h80f1;
    localparam logic [15:0] SYS_MEMORY_BAD    = 16'hffec;
    localparam logic [15:0] SYS_IO_BUS        = 16'h80ca;
    localparam logic [15:0] SYS_IO_BUS_DET    = 16'h0a0a;
    localparam logic [15:0] SYS_TOO_MANY_IO   = 16'h80e1;
    localparam logic [15:0] SYS_TOO_MANY_DET  = 16'h2000;
    localparam logic [15:0] SYS_PROGRAM       = 16'h80f0;
    localparam logic [15:0] SYS_PROGRAM_BAD   = 16'h00ff;
    localparam logic [15:0] SYS_CYCLE_OVER    = 16'h809f;
    localparam logic [15:0] SYS_CYCLE_DET     = 16'h0000;
    // Error log
    localparam int          LOG_DEPTH         = 20;
    // Register byte offsets
    localparam logic [7:0]  OFS_STATUS        = 8'h00;
    localparam logic [7:0]  OFS_ERR_CODE      = 8'h04;
    localparam logic [7:0]  OFS_SYS_ALARM     = 8'h08;
    localparam logic [7:0]  OFS_LOG_INDEX     = 8'h0c;
    localparam logic [7:0]  OFS_LOG_CODE      = 8'h10;
    localparam logic [7:0]  OFS_LOG_TIME      = 8'h14;
    localparam logic [7:0]  OFS_IRQ_STATUS    = 8'h18;
    localparam logic [7:0]  OFS_IRQ_MASK      = 8'h1c;
    // Reset values
    localparam logic [15:0] RST_SYS_ALARM     = 16'h0000;
    localparam logic [15:0] RST_ERR_CODE      = 16'h0000;
    localparam logic [1:0]  RST_IRQ_MASK      = 2'h0;
    // Interrupt status bit positions
    localparam int          IRQ_FATAL         = 0;
    localparam int          IRQ_INSTR_ERR     = 1;

    // One instruction issued by the scan engine
    typedef struct packed {
        logic        valid;
        logic [7:0]  func_code;
        logic        num_is_const;
        logic [15:0] alarm_num;
        logic [15:0] src_word;
        logic [15:0] src_next;
    } faer_issue_t;

    // Another error source of the controller
    typedef struct packed {
        logic        valid;
        logic [15:0] code;
    } faer_ext_err_t;
endpackage : faer_pkg
`default_nettype wire

// [core/faer_top.sv]
// Severe alarm instruction unit with error code word, log and flags
// Function
// - Alarm number constant only, range 1..511
// - User fatal error when number differs
// - Source is message pointer or constant
// - Equal number raises system error from source
// - Invalid system code or details flags error
// - Instruction error flag off otherwise
// - Any generated error sets fatal alarm flag
// - Log keeps code and time, twenty errors
// - User codes C101..C2FF map from number
// - Simultaneous errors store most serious code
// - Fatal error stops program operation
// - Decode function code 007 as this instruction
// - Higher code value means more serious
// - Error indicator lit on user fatal error
//
// The register addresses and register access over Wishbone were left to the implementer.
`default_nettype none
module faer_top
    import faer_pkg::*;
#(
    parameter int TIME_W = 32
) (
    input  wire logic                    clk,
    input  wire logic                    rstn,
    input  wire faer_pkg::faer_issue_t   issue,
    input  wire faer_pkg::faer_ext_err_t ext_err,
    input  wire logic [TIME_W-1:0]       time_now,
    output logic                         instruction_error_flag,
    output logic                         fatal_alarm_flag,
    output logic                         program_stop,
    output logic                         err_indicator,
    output logic                         irq,
    input  wire logic                    wb_cyc_i,
    input  wire logic                    wb_stb_i,
    input  wire logic                    wb_we_i,
    input  wire logic [7:0]              wb_adr_i,
    input  wire logic [3:0]              wb_sel_i,
    input  wire logic [31:0]             wb_dat_i,
    output logic [31:0]                  wb_dat_o,
    output logic                         wb_ack_o
);
    import faer_pkg::*;

    localparam int IW = $clog2(LOG_DEPTH);

    // ==========================================================
    // State
    // ==========================================================
    logic              perr_q, perr_d;
    logic              fatal_q, fatal_d;
    logic              stop_q, stop_d;
    logic              led_q, led_d;
    logic              irq_q, irq_d;
    logic [15:0]       err_code_q, err_code_d;
    logic [15:0]       sys_alarm_q, sys_alarm_d;
    logic [IW-1:0]     log_idx_q, log_idx_d;
    logic [IW-1:0]     log_wp_q, log_wp_d;
    logic [IW:0]       log_cnt_q, log_cnt_d;
    logic [1:0]        irq_st_q, irq_st_d;
    logic [1:0]        irq_mask_q, irq_mask_d;
    logic [31:0]       rdat_q, rdat_d;
    logic              ack_q, ack_d;

    // Log storage, written only from the registered path below
    logic [15:0]       log_code_mem [LOG_DEPTH];
    logic [TIME_W-1:0] log_time_mem [LOG_DEPTH];

    // ==========================================================
    // Instruction decode and checks
    // ==========================================================
    logic        exec, num_ok, is_sys, sys_ok, gen_err, instr_bad;
    logic [15:0] new_code, win_code;
    logic        log_we;

    // System codes only pass with matching detail patterns
    function automatic logic sys_code_valid(input logic [15:0] c,
                                            input logic [15:0] d);
        logic ok;
        ok = 1'b0;
        case (c)
            SYS_MEMORY:      ok = ((d & SYS_MEMORY_BAD) == 16'h0000);
            SYS_IO_BUS:      ok = (d == SYS_IO_BUS_DET);
            SYS_TOO_MANY_IO: ok = (d == SYS_TOO_MANY_DET);
            SYS_PROGRAM:     ok = ((d & SYS_PROGRAM_BAD) == 16'h0000);
            SYS_CYCLE_OVER:  ok = (d == SYS_CYCLE_DET);
            default:         ok = 1'b0;
        endcase
        return ok;
    endfunction : sys_code_valid

    // Halted program issues nothing, so late issues are dropped
    always_comb begin
        exec   = issue.valid && !stop_q
                 && (issue.func_code == FUNC_SEVERE_ALARM);
        num_ok = issue.num_is_const
                 && (issue.alarm_num >= ALARM_NUM_MIN)
                 && (issue.alarm_num <= ALARM_NUM_MAX);
        // A number equal to the system word selects system mode
        is_sys = (issue.alarm_num == sys_alarm_q);
        sys_ok = sys_code_valid(issue.src_word, issue.src_next);
        // Source word only carries a message pointer in user mode
        new_code = is_sys ? issue.src_word
                          : (USER_CODE_BASE + issue.alarm_num);
        gen_err  = exec && num_ok && (!is_sys || sys_ok);
        // Bad operand: range, constness or a refused system code
        instr_bad = exec && !(num_ok && (!is_sys || sys_ok));
    end

    // Most serious of the new errors this cycle, by code value
    // One log slot per cycle, so the lower code goes unlogged
    always_comb begin
        win_code = 16'h0000;
        log_we   = 1'b0;
        if (gen_err && ext_err.valid) begin
            win_code = (new_code > ext_err.code) ? new_code
                                                 : ext_err.code;
            log_we   = 1'b1;
        end else if (gen_err) begin
            win_code = new_code;
            log_we   = 1'b1;
        end else if (ext_err.valid) begin
            win_code = ext_err.code;
            log_we   = 1'b1;
        end
    end

    // ==========================================================
    // Wishbone classic slave and control next state
    // ==========================================================
    logic        req, wr, rd;
    logic [31:0] wmask;
    logic [31:0] status_w;

    // Ack one cycle after the take; a high ack blocks a second take
    always_comb begin
        req   = wb_cyc_i && wb_stb_i && !ack_q;
        wr    = req && wb_we_i;
        rd    = req && !wb_we_i;
        wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                 {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

        // Status: log count in 10:6, then lamp, stop, fatal, flag
        // Count never passes 20, so its top bit is dropped on purpose
        status_w       = 32'h0000_0000;
        status_w[10:6] = log_cnt_q[IW-1:0];
        status_w[3]    = led_q;
        status_w[2]    = stop_q;
        status_w[1]    = fatal_q;
        status_w[0]    = perr_q;

        perr_d      = perr_q;
        fatal_d     = fatal_q;
        stop_d      = stop_q;
        led_d       = led_q;
        err_code_d  = err_code_q;
        sys_alarm_d = sys_alarm_q;
        log_idx_d   = log_idx_q;
        log_wp_d    = log_wp_q;
        log_cnt_d   = log_cnt_q;
        irq_st_d    = irq_st_q;
        irq_mask_d  = irq_mask_q;
        rdat_d      = 32'h0000_0000;
        ack_d       = req;

        // Each execution rewrites the flag from its own checks
        if (exec) begin
            perr_d = instr_bad;
        end
        // Fatal outcomes stay until reset; nothing here clears them
        if (gen_err) begin
            fatal_d = 1'b1;
            stop_d  = 1'b1;
            led_d   = 1'b1;
        end

        // Keep the worst code seen since reset
        if (log_we && (win_code > err_code_q)) begin
            err_code_d = win_code;
        end

        // Ring log: pointer wraps, oldest entry overwritten
        if (log_we) begin
            log_wp_d = (log_wp_q == IW'(LOG_DEPTH - 1)) ? '0
                       : log_wp_q + 1'b1;
            if (log_cnt_q != (IW+1)'(LOG_DEPTH)) begin
                log_cnt_d = log_cnt_q + 1'b1;
            end
        end

        // Register reads; a read of irq status clears it
        if (rd) begin
            case (wb_adr_i)
                OFS_STATUS:     rdat_d = status_w;
                OFS_ERR_CODE:   rdat_d = {16'h0, err_code_q};
                OFS_SYS_ALARM:  rdat_d = {16'h0, sys_alarm_q};
                OFS_LOG_INDEX:  rdat_d = 32'(log_idx_q);
                OFS_LOG_CODE:   rdat_d = {16'h0, log_code_mem[log_idx_q]};
                OFS_LOG_TIME:   rdat_d = 32'(log_time_mem[log_idx_q]);
                OFS_IRQ_STATUS: begin
                    rdat_d   = {30'h0, irq_st_q};
                    irq_st_d = 2'h0;
                end
                OFS_IRQ_MASK:   rdat_d = {30'h0, irq_mask_q};
                default:        rdat_d = 32'h0000_0000;
            endcase
        end

        // Register writes honour byte lanes
        if (wr) begin
            case (wb_adr_i)
                OFS_SYS_ALARM: begin
                    sys_alarm_d = (sys_alarm_q & ~wmask[15:0])
                                  | (wb_dat_i[15:0] & wmask[15:0]);
                end
                OFS_LOG_INDEX: begin
                    if (wb_sel_i[0]) begin
                        // Indexes past the last slot fall back to 0
                        if (wb_dat_i[7:0] >= 8'(LOG_DEPTH)) begin
                            log_idx_d = '0;
                        end else begin
                            log_idx_d = wb_dat_i[IW-1:0];
                        end
                    end
                end
                OFS_IRQ_MASK: begin
                    if (wb_sel_i[0]) begin
                        irq_mask_d = wb_dat_i[1:0];
                    end
                end
                default: ;
            endcase
        end

        // Events set after the clear so a set wins
        if (gen_err) begin
            irq_st_d[IRQ_FATAL] = 1'b1;
        end
        if (instr_bad) begin
            irq_st_d[IRQ_INSTR_ERR] = 1'b1;
        end
        // Built from next values so irq rises with the status bit
        irq_d = |(irq_st_d & irq_mask_d);
    end

    // ==========================================================
    // Registers
    // ==========================================================
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            perr_q      <= 1'b0;
            fatal_q     <= 1'b0;
            stop_q      <= 1'b0;
            led_q       <= 1'b0;
            irq_q       <= 1'b0;
            err_code_q  <= RST_ERR_CODE;
            sys_alarm_q <= RST_SYS_ALARM;
            log_idx_q   <= '0;
            log_wp_q    <= '0;
            log_cnt_q   <= '0;
            irq_st_q    <= 2'h0;
            irq_mask_q  <= RST_IRQ_MASK;
            rdat_q      <= 32'h0000_0000;
            ack_q       <= 1'b0;
        end else begin
            perr_q      <= perr_d;
            fatal_q     <= fatal_d;
            stop_q      <= stop_d;
            led_q       <= led_d;
            irq_q       <= irq_d;
            err_code_q  <= err_code_d;
            sys_alarm_q <= sys_alarm_d;
            log_idx_q   <= log_idx_d;
            log_wp_q    <= log_wp_d;
            log_cnt_q   <= log_cnt_d;
            irq_st_q    <= irq_st_d;
            irq_mask_q  <= irq_mask_d;
            rdat_q      <= rdat_d;
            ack_q       <= ack_d;
        end
    end

    // Log memory has no reset; unwritten slots count as empty
    always_ff @(posedge clk) begin
        if (log_we) begin
            log_code_mem[log_wp_q] <= win_code;
            log_time_mem[log_wp_q] <= time_now;
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    assign instruction_error_flag = perr_q;
    assign fatal_alarm_flag       = fatal_q;
    assign program_stop           = stop_q;
    assign err_indicator          = led_q;
    assign irq                    = irq_q;
    assign wb_dat_o               = rdat_q;
    assign wb_ack_o               = ack_q;
endmodule : faer_top
`default_nettype wire

// [verif/faer_chk.sv]
// Port checker for the severe alarm unit
`default_nettype none
module faer_chk
    import faer_pkg::*;
(
    input wire logic                  clk,
    input wire logic                  rstn,
    input wire faer_pkg::faer_issue_t issue,
    input wire logic                  instruction_error_flag,
    input wire logic                  fatal_alarm_flag,
    input wire logic                  program_stop,
    input wire logic                  err_indicator,
    input wire logic                  wb_cyc_i,
    input wire logic                  wb_stb_i,
    input wire logic [31:0]           wb_dat_o,
    input wire logic                  wb_ack_o
);
    // ==================================================
    // Instruction acceptance helpers
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    logic take;
    logic good;
    // Only a decoded, unstopped instruction counts
    assign take = issue.valid && !program_stop
                  && issue.func_code == FUNC_SEVERE_ALARM;
    assign good = issue.num_is_const && issue.alarm_num >= ALARM_NUM_MIN
                  && issue.alarm_num <= ALARM_NUM_MAX;
    // ==================================================
    // Assertions
    a_bad_operand: assert property (
        take && !good |=> instruction_error_flag && !fatal_alarm_flag)
        else $error("bad operand not flagged");
    a_one_outcome: assert property (
        take && good |=> fatal_alarm_flag ^ instruction_error_flag)
        else $error("good operand gave wrong outcome");
    a_stop_and_led: assert property (
        fatal_alarm_flag |-> program_stop && err_indicator)
        else $error("fatal without stop or indicator");
    a_fatal_sticky: assert property (
        fatal_alarm_flag |=> fatal_alarm_flag [*8])
        else $error("fatal flag dropped");
    a_fatal_cause: assert property (
        !take |=> !$rose(fatal_alarm_flag))
        else $error("fatal flag without instruction");
    a_stop_refuse: assert property (
        program_stop && issue.valid |=> $stable(instruction_error_flag))
        else $error("instruction ran after stop");
    a_func_decode: assert property (
        issue.valid && issue.func_code != FUNC_SEVERE_ALARM
        |=> $stable(instruction_error_flag) && $stable(fatal_alarm_flag))
        else $error("other function code acted");
    a_ack_once: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus answer not one cycle");
    a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside answer");
    // Main scenarios reached
    c_fatal: cover property ($rose(fatal_alarm_flag));
    c_perr: cover property ($rose(instruction_error_flag));
    c_read: cover property (wb_ack_o && wb_dat_o != 32'h0);
endmodule : faer_chk
bind faer_top faer_chk u_chk (.clk(clk), .rstn(rstn), .issue(issue),
    .instruction_error_flag(instruction_error_flag),
    .fatal_alarm_flag(fatal_alarm_flag), .program_stop(program_stop),
    .err_indicator(err_indicator), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
`default_nettype wire

// [verif/faer_prog.sv]
// Model of the user program issuing alarm instructions
`default_nettype none
module faer_prog
    import faer_pkg::*;
(
    input  wire logic                     clk,
    output var faer_pkg::faer_issue_t     issue,
    output var faer_pkg::faer_ext_err_t   ext_err
);
    timeunit 1ns;
    timeprecision 1ns;
    // Idle until the first call
    initial begin
        issue   = '0;
        ext_err = '0;
    end
    // One pulse per call; operands then flip so stale ones never pass
    task automatic exec(input logic [7:0] f, input logic c,
                        input logic [15:0] n, s, s1, e);
        @(posedge clk);
        issue   <= {1'b1, f, c, n, s, s1};
        ext_err <= {|e, e};
        @(posedge clk);
        issue   <= {1'b0, ~f, ~c, ~n, ~s, ~s1};
        ext_err <= {1'b0, ~e};
    endtask : exec
endmodule : faer_prog
`default_nettype wire

// [verif/faer_top_tb.sv]
// Self-checking bench for the severe alarm unit
`default_nettype none
module faer_top_tb
    import faer_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic          clk, rstn, req, we, ack, perr, fatal, stop, led, irq;
    faer_issue_t   issue;
    faer_ext_err_t ext_err;
    logic [31:0]   tnow, wdat, wdo, rd, sum;
    logic [7:0]    adr;
    int            failures, comparisons;
    logic [16:0]   bad [4] = '{17'h10000, 17'h10200, 17'h1ffff, 17'h00005};
    logic [47:0]   sys [5] = '{48'h80f1_0001_0004, 48'h80ca_0a0a_0000,
        48'h80e1_2000_0000, 48'h80f0_8000_0001, 48'h809f_0000_0001};
    logic [31:0]   sim [3] = '{32'hc200_c200, 32'h8000_c101,
        32'h4000_c101};
    faer_prog prog (.clk(clk), .issue(issue), .ext_err(ext_err));
    faer_top dut (.clk(clk), .rstn(rstn), .issue(issue), .ext_err(ext_err),
        .time_now(tnow), .instruction_error_flag(perr),
        .fatal_alarm_flag(fatal), .program_stop(stop), .err_indicator(led),
        .irq(irq), .wb_cyc_i(req), .wb_stb_i(req), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(wdo),
        .wb_ack_o(ack));
    // ==================================================
    // Clock, checks and bus tasks
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic chk(input logic [31:0] got, exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: %h, expected %h", $time, got, exp);
        end
    endtask : chk
    // Holds the request until ack is seen at an edge
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
        @(posedge clk);
        req  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        do @(posedge clk); while (ack !== 1'b1);
        rd = wdo;
        req  <= 1'b0;
        wdat <= ~d;
    endtask : wb
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        wb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask : rdc
    task automatic do_reset;
        rstn <= 1'b0;
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
    endtask : do_reset
    task automatic give_verdict;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : give_verdict
    // Cuts a hang short well after the expected run
    initial begin
        #200us;
        failures++;
        give_verdict();
    end
    // ==================================================
    // Test sequence
    initial begin
        {rstn, req, we, adr, wdat, tnow} = '0;
        do_reset();
        rdc(OFS_STATUS, 32'h0);
        rdc(OFS_SYS_ALARM, 32'(RST_SYS_ALARM));
        wb(1'b1, OFS_ERR_CODE, 32'hc2ff);
        rdc(OFS_ERR_CODE, 32'(RST_ERR_CODE));
        rdc(8'h20, 32'h0);
        rdc(OFS_IRQ_MASK, 32'(RST_IRQ_MASK));
        // Range ends and a non-constant number
        foreach (bad[i]) begin
            do_reset();
            prog.exec(8'h07, bad[i][16], bad[i][15:0], 16'h0, 16'h0, 16'h0);
            rdc(OFS_STATUS, 32'h1);
        end
        chk(irq, 1'b0);
        wb(1'b1, OFS_IRQ_MASK, 32'h3);
        chk(irq, 1'b1);
        rdc(OFS_IRQ_STATUS, 32'h2);
        rdc(OFS_IRQ_STATUS, 32'h0);
        chk(irq, 1'b0);
        prog.exec(8'h06, 1'b1, 16'h5, 16'h0, 16'h0, 16'h0);
        rdc(OFS_STATUS, 32'h1);
        // Deliberate system errors, bad details first
        foreach (sys[i]) begin
            do_reset();
            wb(1'b1, OFS_SYS_ALARM, 32'h000a);
            prog.exec(8'h07, 1'b1, 16'h000a, sys[i][47:32], sys[i][15:0],
                      16'h0);
            rdc(OFS_STATUS, 32'h1);
            prog.exec(8'h07, 1'b1, 16'h000a, sys[i][47:32], sys[i][31:16],
                      16'h0);
            rdc(OFS_STATUS, 32'h4e);
            rdc(OFS_ERR_CODE, 32'(sys[i][47:32]));
            prog.exec(8'h07, 1'b1, 16'h0, 16'h0, 16'h0, 16'h0);
            rdc(OFS_STATUS, 32'h4e);
        end
        // User fatal error at the top number
        do_reset();
        tnow <= 32'h5a5a;
        prog.exec(8'h07, 1'b1, 16'h01ff, 16'h0, 16'h0, 16'h0);
        rdc(OFS_ERR_CODE, 32'hc2ff);
        rdc(OFS_STATUS, 32'h4e);
        rdc(OFS_LOG_TIME, 32'h5a5a);
        rdc(OFS_IRQ_STATUS, 32'h1);
        // Simultaneous error from elsewhere, higher and lower
        foreach (sim[i]) begin
            do_reset();
            prog.exec(8'h07, 1'b1, 16'h1, 16'h0, 16'h0, sim[i][31:16]);
            rdc(OFS_ERR_CODE, 32'(sim[i][15:0]));
            rdc(OFS_LOG_CODE, 32'(sim[i][15:0]));
            rdc(OFS_STATUS, 32'h4e);
        end
        // Log overrun: oldest three codes must be gone
        do_reset();
        for (int i = 0; i < 23; i++)
            prog.exec(8'h00, 1'b1, 16'h1, 16'h0, 16'h0, 16'(16'h100 + i));
        rdc(OFS_STATUS, 32'h500);
        {rd, sum} = '0;
        for (int i = 0; i < LOG_DEPTH; i++) begin
            wb(1'b1, OFS_LOG_INDEX, 32'(i));
            wb(1'b0, OFS_LOG_CODE, 32'h0);
            sum = sum + rd - 32'h100 - 32'(i + 3);
        end
        chk(sum, 32'h0);
        wb(1'b1, OFS_LOG_INDEX, 32'h21);
        rdc(OFS_LOG_INDEX, 32'h0);
        give_verdict();
    end
endmodule : faer_top_tb
`default_nettype wire
